//--- logic/resolver_serial_readout_port.sv
`timescale 1ns/100ps
`include "rdc_serial_regs.svh"
module resolver_serial_readout_port (
  input wire logic mclk,
  input wire logic rst,
  input wire logic sclk,
  input wire logic sdi,
  input wire logic frame_sync_n,
  input wire logic serial_select_n,
  input wire logic mode_select_0,
  input wire logic mode_select_1,
  input wire logic capture_n,
  input wire logic [15:0] position_in,
  input wire logic [15:0] velocity_in,
  input wire logic [7:0] fault_detect_in,
  output logic sdo_out,
  output logic sdo_oe,
  output logic tracking_loss_fault_n,
  output logic signal_degradation_fault_n,
  output logic port_active,
  output logic config_mode
);
  logic [6:0] pins_s;
  logic s_sclk, s_sdi, s_fs_n, s_sel_n, s_m0, s_m1, s_cap_n;
  logic sclk_d_r, sclk_d_nxt, fs_d_r, fs_d_nxt, cap_d_r, cap_d_nxt;
  logic sclk_rise, sclk_fall, fs_fall, fs_rise, cap_fall, sel, cfg;

  // Every control pin crosses two flops before any logic sees it
  pin_sync #(.W(7)) u_sync (
    .mclk(mclk),
    .rst(rst),
    .d({sclk, sdi, frame_sync_n, serial_select_n, mode_select_0, mode_select_1, capture_n}),
    .q(pins_s)
  );
  assign {s_sclk, s_sdi, s_fs_n, s_sel_n, s_m0, s_m1, s_cap_n} = pins_s;

  // Edge detection on synchronised pins
  always_comb begin
    sclk_d_nxt = s_sclk;
    fs_d_nxt = s_fs_n;
    cap_d_nxt = s_cap_n;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      // Same level as the synchroniser resets to, so no false fall follows reset
      sclk_d_r <= 1'b0;
      fs_d_r <= 1'b0;
      cap_d_r <= 1'b0;
    end else begin
      sclk_d_r <= sclk_d_nxt;
      fs_d_r <= fs_d_nxt;
      cap_d_r <= cap_d_nxt;
    end
  end

  assign sclk_rise = s_sclk & ~sclk_d_r;
  assign sclk_fall = ~s_sclk & sclk_d_r;
  assign fs_fall = ~s_fs_n & fs_d_r;
  assign fs_rise = s_fs_n & ~fs_d_r;
  assign cap_fall = ~s_cap_n & cap_d_r;
  assign sel = ~s_sel_n;
  assign cfg = s_m0 & s_m1;

  // Capture snapshot and fault latch
  rdc_serial_pkg::sample_t smp_r, smp_nxt;
  logic [7:0] fault_lat_r, fault_lat_nxt;
  logic fault_read_r, fault_read_nxt, fault_read_set;
  logic lot_n_r, lot_n_nxt, dos_n_r, dos_n_nxt;

  always_comb begin
    smp_nxt = smp_r;
    fault_lat_nxt = fault_lat_r | fault_detect_in;
    fault_read_nxt = fault_read_r;
    if (cap_fall) begin
      smp_nxt.pos = position_in;
      smp_nxt.vel = velocity_in;
      smp_nxt.fault = fault_lat_r | fault_detect_in;
      fault_read_nxt = 1'b0;
      // First strobe after a read clears; live faults still win
      if (fault_read_r) begin
        fault_lat_nxt = fault_detect_in;
      end
    end
    if (fault_read_set) begin
      fault_read_nxt = 1'b1;
    end
    lot_n_nxt = ~|(fault_lat_nxt & `LOT_MASK);
    dos_n_nxt = ~|(fault_lat_nxt & `DOS_MASK);
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      smp_r <= '{pos: `WORD_RST, vel: `WORD_RST, fault: `FAULT_RST};
      fault_lat_r <= `FAULT_RST;
      fault_read_r <= 1'b0;
      lot_n_r <= 1'b0;
      dos_n_r <= 1'b0;
    end else begin
      smp_r <= smp_nxt;
      fault_lat_r <= fault_lat_nxt;
      fault_read_r <= fault_read_nxt;
      lot_n_r <= lot_n_nxt;
      dos_n_r <= dos_n_nxt;
    end
  end

  // Frame sequencer and shift registers
  rdc_serial_pkg::port_state_t st_r, st_nxt;
  logic [23:0] osr_r, osr_nxt;
  logic [7:0] isr_r, isr_nxt;
  logic [4:0] bcnt_r, bcnt_nxt;
  logic first_r, first_nxt, fcfg_r, fcfg_nxt;
  logic sdo_r, sdo_nxt, oe_r, oe_nxt;
  logic pend_r, pend_nxt;
  logic [7:0] pdat_r, pdat_nxt;
  logic act_r, act_nxt, cfgo_r, cfgo_nxt;
  logic [7:0] cfg_out_r;
  logic [7:0] addr_r, addr_nxt;
  logic [15:0] word16;
  logic buf_in_ready;

  // Mode selects choose the normal-mode word
  assign word16 = (s_m0 & ~s_m1) ? smp_r.vel : smp_r.pos;

  always_comb begin
    st_nxt = st_r;
    osr_nxt = osr_r;
    isr_nxt = isr_r;
    bcnt_nxt = bcnt_r;
    first_nxt = first_r;
    fcfg_nxt = fcfg_r;
    oe_nxt = oe_r;
    pend_nxt = pend_r & ~buf_in_ready;
    pdat_nxt = pdat_r;
    fault_read_set = 1'b0;
    case (st_r)
      rdc_serial_pkg::PS_IDLE: begin
        if (sel & fs_fall) begin
          st_nxt = rdc_serial_pkg::PS_SHIFT;
          // Top bit is on the pin before the host's first edge
          osr_nxt = cfg ? {cfg_out_r, 16'h0000} : {word16, smp_r.fault};
          isr_nxt = 8'h00;
          bcnt_nxt = 5'h00;
          first_nxt = 1'b1;
          fcfg_nxt = cfg;
          oe_nxt = 1'b1;
        end
      end
      rdc_serial_pkg::PS_SHIFT: begin
        if (~sel | fs_rise) begin
          st_nxt = rdc_serial_pkg::PS_CLOSE;
          oe_nxt = 1'b0;
        end else begin
          if (sclk_rise) begin
            first_nxt = 1'b0;
            // First rising edge holds the top bit, later ones advance
            if (!first_r) begin
              if (fcfg_r) begin
                osr_nxt = {osr_r[22:16], isr_r[0], 16'h0000};
              end else begin
                osr_nxt = {osr_r[22:0], 1'b0};
              end
            end
          end
          if (sclk_fall) begin
            isr_nxt = {isr_r[6:0], s_sdi};
            if (bcnt_r != 5'h1F) begin
              bcnt_nxt = bcnt_r + 5'h01;
            end
          end
        end
      end
      rdc_serial_pkg::PS_CLOSE: begin
        // Waits here while a previous frame is still unaccepted
        if (!pend_r || buf_in_ready) begin
          st_nxt = rdc_serial_pkg::PS_IDLE;
          if (fcfg_r && bcnt_r >= 5'(`FRAME_BITS)) begin
            pend_nxt = 1'b1;
            pdat_nxt = isr_r;
          end
          if (fcfg_r && addr_r == `ADDR_FAULT) begin
            fault_read_set = 1'b1;
          end
        end
      end
      default: begin
        st_nxt = rdc_serial_pkg::PS_IDLE;
        oe_nxt = 1'b0;
      end
    endcase
    sdo_nxt = oe_nxt & osr_nxt[23];
    act_nxt = sel;
    cfgo_nxt = cfg;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_r <= rdc_serial_pkg::PS_IDLE;
      osr_r <= 24'h00_0000;
      isr_r <= 8'h00;
      bcnt_r <= 5'h00;
      first_r <= 1'b0;
      fcfg_r <= 1'b0;
      sdo_r <= 1'b0;
      oe_r <= 1'b0;
      pend_r <= 1'b0;
      pdat_r <= 8'h00;
      act_r <= 1'b0;
      cfgo_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      osr_r <= osr_nxt;
      isr_r <= isr_nxt;
      bcnt_r <= bcnt_nxt;
      first_r <= first_nxt;
      fcfg_r <= fcfg_nxt;
      sdo_r <= sdo_nxt;
      oe_r <= oe_nxt;
      pend_r <= pend_nxt;
      pdat_r <= pdat_nxt;
      act_r <= act_nxt;
      cfgo_r <= cfgo_nxt;
    end
  end

  // Received frames queue here; drain stalls on a capture cycle
  logic bv, br;
  logic [7:0] bd;
  assign br = ~cap_fall;
  two_entry_buffer u_buf (
    .mclk(mclk),
    .rst(rst),
    .in_valid(pend_r),
    .in_ready(buf_in_ready),
    .in_data(pdat_r),
    .out_valid(bv),
    .out_ready(br),
    .out_data(bd)
  );

  // Configuration register file
  logic addr_ok_r, addr_ok_nxt;
  logic [6:0] rw_r [8];
  logic [6:0] rw_nxt [8];
  logic [6:0] last_wr_r, last_wr_nxt;
  logic [7:0] cfg_out_nxt;

  function automatic logic is_rw(input logic [7:0] a);
    return a[7:3] == 5'(`ADDR_RW_BASE >> 3);
  endfunction : is_rw

  function automatic logic [7:0] read_reg(input logic [7:0] a);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      `ADDR_POS_HI: v = smp_r.pos[15:8];
      `ADDR_POS_LO: v = smp_r.pos[7:0];
      `ADDR_VEL_HI: v = smp_r.vel[15:8];
      `ADDR_VEL_LO: v = smp_r.vel[7:0];
      `ADDR_FAULT: v = smp_r.fault;
      default: begin
        if (is_rw(a)) begin
          v = {rw_r[a[2:0]] != last_wr_r, rw_r[a[2:0]]};
        end
      end
    endcase
    return v;
  endfunction : read_reg

  always_comb begin
    addr_nxt = addr_r;
    addr_ok_nxt = addr_ok_r;
    rw_nxt = rw_r;
    last_wr_nxt = last_wr_r;
    if (bv & br) begin
      if (bd[`ADDR_FLAG_BIT]) begin
        addr_nxt = bd;
        addr_ok_nxt = 1'b1;
      end else if (addr_ok_r && is_rw(addr_r)) begin
        rw_nxt[addr_r[2:0]] = bd[6:0];
        last_wr_nxt = bd[6:0];
      end
    end
    // Address is never cleared on mode exit
    cfg_out_nxt = addr_ok_nxt ? read_reg(addr_nxt) : 8'h00;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      addr_r <= 8'h00;
      addr_ok_r <= 1'b0;
      rw_r <= '{default: 7'h00};
      last_wr_r <= 7'h00;
      cfg_out_r <= 8'h00;
    end else begin
      addr_r <= addr_nxt;
      addr_ok_r <= addr_ok_nxt;
      rw_r <= rw_nxt;
      last_wr_r <= last_wr_nxt;
      cfg_out_r <= cfg_out_nxt;
    end
  end

  assign sdo_out = sdo_r;
  assign sdo_oe = oe_r;
  assign tracking_loss_fault_n = lot_n_r;
  assign signal_degradation_fault_n = dos_n_r;
  assign port_active = act_r;
  assign config_mode = cfgo_r;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  a_capture_copy: assert property (cap_fall |=> smp_r.pos == $past(position_in) && smp_r.vel == $past(velocity_in))
    else $error("capture did not copy words");
  a_frame_open: assert property (st_r == rdc_serial_pkg::PS_IDLE && sel && fs_fall |=> sdo_oe ##1 sdo_oe || !sel || fs_rise)
    else $error("frame fall did not enable output");
  a_frame_close: assert property (st_r == rdc_serial_pkg::PS_SHIFT && fs_rise |=> !sdo_oe)
    else $error("frame rise did not release output");
  a_top_bit: assert property (st_r == rdc_serial_pkg::PS_IDLE && sel && fs_fall && !cfg |=> sdo_out == $past(word16[15]))
    else $error("top bit not presented");
  a_first_hold: assert property (st_r == rdc_serial_pkg::PS_SHIFT && first_r && sclk_rise && sel && !fs_rise
    |=> $stable(sdo_out)) else $error("top bit lost on first edge");
  a_sdi_sample: assert property (st_r == rdc_serial_pkg::PS_SHIFT && sclk_fall && sel && !fs_rise
    |=> isr_r[0] == $past(s_sdi)) else $error("input not sampled on fall");
  a_addr_decode: assert property (bv && br && bd[7] |=> addr_r == $past(bd))
    else $error("address frame not latched");
  a_fault_pins: assert property (|fault_detect_in |=> !(tracking_loss_fault_n && signal_degradation_fault_n))
    else $error("fault did not reach pins");
  a_rw_error: assert property (addr_ok_r && is_rw(addr_r) && !(bv && br) |=> cfg_out_r[`ERR_BIT]
    == ($past(rw_r[addr_r[2:0]]) != $past(last_wr_r))) else $error("readback error bit wrong");
  // Select gating, quiet close, config width and the clearing strobe
  a_select_gate: assert property (st_r == rdc_serial_pkg::PS_IDLE && !sel |=> st_r == rdc_serial_pkg::PS_IDLE)
    else $error("frame opened while deselected");
  a_close_quiet: assert property (st_r == rdc_serial_pkg::PS_CLOSE |-> !sdo_oe && !sdo_out)
    else $error("output driven after frame close");
  a_cfg_width: assert property (st_r == rdc_serial_pkg::PS_SHIFT && fcfg_r |-> osr_r[15:0] == 16'h0000)
    else $error("config word wider than a byte");
  a_fault_clear: assert property (cap_fall && fault_read_r && !(|fault_detect_in) |=> fault_lat_r == 8'h00)
    else $error("fault latch not cleared");
endmodule : resolver_serial_readout_port

//--- logic/rdc_serial_regs.svh
// Notes on behaviour
// - Port works only while serial select low
// - Frame fall enables lines, rise releases them
// - Normal mode shifts 24 bits, rising edges
// - Input line sampled on serial falling edge
// - Config input addresses and daisy-chains
// - Both mode selects high means configuration
// - Address then data frame, latched on rise
// - Top bit one is address, zero data
// - Address write loads register into output
// - Config output word is eight bits
// - Readback error bit flags mismatch with write
// - Capture fall copies position, velocity, faults
// - Mode selects pick position or velocity word
// - MSB first, angle high, faults low
// - Position is unsigned binary
// - Velocity is twos complement
// - Any fault drives at least one fault output low
// - Capture, read faults, capture again clears
// - Persistent fault reasserts outputs
// - Reset zeroes position, pulls faults low
// - Last address survives leaving configuration
`ifndef RDC_SERIAL_REGS_SVH
`define RDC_SERIAL_REGS_SVH
`define NORM_WORD_BITS 24
`define FRAME_BITS 8
`define ADDR_FLAG_BIT 7
`define ERR_BIT 7
`define ADDR_POS_HI 8'h80
`define ADDR_POS_LO 8'h81
`define ADDR_VEL_HI 8'h82
`define ADDR_VEL_LO 8'h83
`define ADDR_RW_BASE 8'h88
`define ADDR_FAULT 8'hFF
`define FAULT_RST 8'h80
`define LOT_MASK 8'h81
`define DOS_MASK 8'hFE
`define WORD_RST 16'h0000
`endif

//--- logic/rdc_serial_pkg.sv
package rdc_serial_pkg;
  // Snapshot taken by the capture strobe
  typedef struct packed {
    logic [15:0] pos;
    logic [15:0] vel;
    logic [7:0] fault;
  } sample_t;
  // Serial frame sequencer
  typedef enum logic [2:0] {
    PS_IDLE = 3'b001,
    PS_SHIFT = 3'b010,
    PS_CLOSE = 3'b100
  } port_state_t;
endpackage : rdc_serial_pkg

//--- logic/pin_sync.sv
`timescale 1ns/100ps
module pin_sync #(
  parameter int W = 7
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;
  // Two stages; the first is read only by the second
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule : pin_sync

//--- logic/two_entry_buffer.sv
`timescale 1ns/100ps
module two_entry_buffer (
  input wire logic mclk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [7:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [7:0] out_data
);
  logic [7:0] mem_r [2];
  logic [7:0] mem_nxt [2];
  logic wp_r, wp_nxt, rp_r, rp_nxt;
  logic [1:0] cnt_r, cnt_nxt;
  logic push, pop;

  // Honest full and empty from the occupancy count
  always_comb begin
    in_ready = (cnt_r != 2'h2);
    out_valid = (cnt_r != 2'h0);
    out_data = mem_r[rp_r];
    push = in_valid & in_ready;
    pop = out_valid & out_ready;
    mem_nxt = mem_r;
    if (push) begin
      mem_nxt[wp_r] = in_data;
    end
    wp_nxt = push ? ~wp_r : wp_r;
    rp_nxt = pop ? ~rp_r : rp_r;
    cnt_nxt = cnt_r + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      mem_r[0] <= 8'h00;
      mem_r[1] <= 8'h00;
      wp_r <= 1'b0;
      rp_r <= 1'b0;
      cnt_r <= 2'h0;
    end else begin
      mem_r <= mem_nxt;
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end
endmodule : two_entry_buffer

//--- dv/host_serial_model.sv
`timescale 1ns/100ps
module host_serial_model (
  input wire logic mclk,
  input wire logic sdo_out,
  input wire logic sdo_oe,
  output logic sclk,
  output logic sdi,
  output logic frame_sync_n
);
  logic in_frame;
  logic last_sdo;
  logic oe_seen;
  // Released line shows the inverse of its last value, never a stale copy
  wire logic sdo_line = sdo_oe ? sdo_out : ~last_sdo;

  // Idle state: clock parked low, frame closed
  initial begin
    sclk = 1'b0;
    sdi = 1'b0;
    frame_sync_n = 1'b1;
    in_frame = 1'b0;
    last_sdo = 1'b0;
    oe_seen = 1'b0;
  end

  // Outside frames the data pin wanders so the device cannot lean on it
  always @(negedge mclk) begin
    if (!in_frame) sdi <= ~sdi;
    if (sdo_oe) last_sdo <= sdo_out;
    if (in_frame && sdo_oe) oe_seen <= 1'b1;
  end

  // One framed transfer of n bits, MSB first; sclk runs at 800 ns
  task automatic xfer(input int n, input logic [23:0] tx, output logic [23:0] rx);
    rx = '0;
    in_frame = 1'b1;
    oe_seen = 1'b0;
    frame_sync_n = 1'b0;
    repeat (6) @(negedge mclk);
    for (int i = 0; i < n; i++) begin
      sclk = 1'b1;
      sdi = tx[n-1-i];
      repeat (4) @(negedge mclk);
      sclk = 1'b0;
      // Sample well after the fall, clear of the device's update
      repeat (2) @(negedge mclk);
      rx = {rx[22:0], sdo_line};
      repeat (2) @(negedge mclk);
    end
    frame_sync_n = 1'b1;
    in_frame = 1'b0;
    repeat (6) @(negedge mclk);
  endtask : xfer
endmodule : host_serial_model

//--- dv/resolver_serial_readout_port_bench.sv
`timescale 1ns/100ps
module resolver_serial_readout_port_bench;
  logic mclk, rst, sclk, sdi, frame_sync_n, serial_select_n, mode_select_0, mode_select_1, capture_n;
  logic [15:0] position_in, velocity_in;
  logic [7:0] fault_detect_in;
  logic sdo_out, sdo_oe, tracking_loss_fault_n, signal_degradation_fault_n, port_active, config_mode;
  logic [23:0] rx;
  int miscompares, n_tests;
  localparam logic [7:0] LOT_M = 8'h81;
  localparam logic [7:0] DOS_M = 8'hFE;

  // 100 ns clock
  always #50 mclk = ~mclk;

  resolver_serial_readout_port dut_u (
    .mclk(mclk), .rst(rst), .sclk(sclk), .sdi(sdi), .frame_sync_n(frame_sync_n),
    .serial_select_n(serial_select_n), .mode_select_0(mode_select_0), .mode_select_1(mode_select_1),
    .capture_n(capture_n), .position_in(position_in), .velocity_in(velocity_in),
    .fault_detect_in(fault_detect_in), .sdo_out(sdo_out), .sdo_oe(sdo_oe),
    .tracking_loss_fault_n(tracking_loss_fault_n), .signal_degradation_fault_n(signal_degradation_fault_n),
    .port_active(port_active), .config_mode(config_mode)
  );

  host_serial_model host_u (
    .mclk(mclk), .sdo_out(sdo_out), .sdo_oe(sdo_oe), .sclk(sclk), .sdi(sdi), .frame_sync_n(frame_sync_n)
  );

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic flt_chk(input logic [1:0] exp);
    chk({22'h0, tracking_loss_fault_n, signal_degradation_fault_n}, {22'h0, exp});
  endtask : flt_chk

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : tally_and_finish

  task automatic wait_n(input int n);
    repeat (n) @(negedge mclk);
  endtask : wait_n

  // Mode pins pass a sync pipeline, so give them time to land
  task automatic set_mode(input logic m1, input logic m0);
    mode_select_1 = m1;
    mode_select_0 = m0;
    wait_n(6);
  endtask : set_mode

  task automatic capture;
    capture_n = 1'b0;
    wait_n(4);
    capture_n = 1'b1;
    wait_n(6);
  endtask : capture

  task automatic frame(input logic [23:0] tx, input int n = 8);
    host_u.xfer(n, tx, rx);
  endtask : frame

  // Watchdog: the whole sequence needs well under a millisecond
  initial begin
    #3_000_000;
    miscompares++;
    $display("watchdog expired");
    tally_and_finish();
  end

  // Main sequence
  initial begin
    mclk = 1'b0;
    rst = 1'b1;
    serial_select_n = 1'b0;
    mode_select_0 = 1'b0;
    mode_select_1 = 1'b0;
    capture_n = 1'b1;
    position_in = 16'hA5C3;
    velocity_in = 16'h8001;
    fault_detect_in = 8'h00;
    miscompares = 0;
    n_tests = 0;
    wait_n(3);
    flt_chk(2'b00);
    chk(24'(sdo_oe), 24'h0);
    wait_n(3);
    rst = 1'b0;
    wait_n(6);
    flt_chk(2'b00);
    $display("test reset done");

    // Snapshot, then move the integrators so only the snapshot can match
    capture();
    position_in = 16'h1234;
    velocity_in = 16'h7FFF;
    frame(24'h0, 24);
    chk(rx, 24'hA5_C380);
    chk(24'(host_u.oe_seen), 24'h1);
    chk(24'(sdo_oe), 24'h0);
    set_mode(1'b0, 1'b1);
    frame(24'h0, 16);
    chk(rx, 24'h8001);
    serial_select_n = 1'b1;
    wait_n(6);
    chk(24'(port_active), 24'h0);
    frame(24'h0, 24);
    chk(24'(host_u.oe_seen), 24'h0);
    serial_select_n = 1'b0;
    wait_n(6);
    $display("test normal done");

    // Each address frame reads back what the previous address selected
    set_mode(1'b1, 1'b1);
    chk(24'(config_mode), 24'h1);
    frame(8'h88);
    frame(8'h55);
    frame(8'h88);
    chk(rx, 24'h55);
    frame(8'h89);
    frame(8'h2A);
    frame(8'h88);
    chk(rx, 24'h2A);
    frame(8'h80);
    chk(rx, 24'hD5);
    frame(8'h80);
    chk(rx, 24'hA5);
    set_mode(1'b0, 1'b0);
    set_mode(1'b1, 1'b1);
    frame(8'h00);
    chk(rx, 24'hA5);
    frame(24'h5A80, 16);
    chk(rx, 24'hA55A);
    $display("test config done");

    // Fault read and clear, then each condition alone
    frame(8'hFF);
    frame(8'hFF);
    chk(rx, 24'h80);
    flt_chk(2'b00);
    capture();
    flt_chk(2'b11);
    for (int i = 0; i < 8; i++) begin
      fault_detect_in = 8'h01 << i;
      wait_n(3);
      fault_detect_in = 8'h00;
      wait_n(3);
      flt_chk({~LOT_M[i], ~DOS_M[i]});
      frame(8'hFF);
      capture();
      flt_chk(2'b11);
    end
    fault_detect_in = 8'h80;
    wait_n(3);
    frame(8'hFF);
    capture();
    flt_chk(2'b00);
    fault_detect_in = 8'h00;
    frame(8'h80);
    frame(8'h80);
    chk(rx, 24'h12);
    $display("test faults done");
    tally_and_finish();
  end
endmodule : resolver_serial_readout_port_bench
